//--- verilog/nvs_sequencer.sv
// This file holds the flash command timing sequencer top module.
// It assumes command fields are stable while CMD_START is high and
// NONBLANK comes from logic on the same clock.
`include "nvs_regs.svh"
`timescale 1ns/100ps
module nvs_sequencer
  import nvs_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [7:0] NVM_CLOCK_DIVIDER,
  input wire logic CMD_START,
  input wire nvs_cmd_t CMD,
  input wire logic NONBLANK,
  output logic BUSY,
  output logic CMD_COMPLETE,
  output logic CMD_ERROR,
  output logic BLANK_FAIL
);
  // ****************************************************************
  // Operating clock
  // ****************************************************************
  logic op_tick; // One pulse per operating clock cycle.

  nvs_clk_div u_div (
    .sys_clk(SYS_CLK),
    .rst(RST),
    .nvm_clock_divider(NVM_CLOCK_DIVIDER),
    .op_tick(op_tick)
  );

  // ****************************************************************
  // Duration lookup
  // ****************************************************************
  logic [19:0] bus_need; // Bus cycles demanded by the command.
  logic [19:0] op_need; // Operating cycles demanded by the command.
  logic known; // Command code is recognised.
  logic early_exit; // Command may stop at the first non-blank word.
  logic [19:0] nw; // Word count widened.
  logic [19:0] bc; // Boundary flag widened.

  // Selects both counts from the code; unknown codes are flagged.
  always_comb begin
    nw = {17'h0_0000, CMD.word_count};
    bc = {19'h0_0000, CMD.row_boundary_crossed};
    bus_need = 20'h0_0001;
    op_need = 20'h0_0000;
    known = 1'b1;
    early_exit = 1'b0;
    case (CMD.flash_command_code)
      `NVS_CMD_CHK_ALL: begin
        bus_need = `NVS_BUS_CHK_ALL; // [R3]
        early_exit = 1'b1;
      end
      `NVS_CMD_CHK_BLK: begin
        bus_need = CMD.data_block ? `NVS_BUS_CHK_DBLK : `NVS_BUS_CHK_PBLK; // [R4]
        early_exit = 1'b1;
      end
      `NVS_CMD_CHK_PSEC: begin
        bus_need = `NVS_BUS_SEC_SETUP + {4'h0, CMD.phrase_count}; // [R5]
        early_exit = 1'b1;
      end
      `NVS_CMD_RD_ONCE: bus_need = `NVS_BUS_RD_ONCE; // [R6]
      `NVS_CMD_PGM_P: begin
        bus_need = CMD.worst_case ? `NVS_BUS_PGM_P_MAX : `NVS_BUS_PGM_P_TYP; // [R7]
        op_need = `NVS_OP_PGM;
      end
      `NVS_CMD_PGM_ONCE: begin
        bus_need = `NVS_BUS_PGM_ONCE; // [R8]
        op_need = `NVS_OP_PGM;
      end
      `NVS_CMD_ERS_ALL: begin
        bus_need = `NVS_BUS_ERS_ALL; // [R9]
        op_need = `NVS_OP_MASS;
      end
      `NVS_CMD_ERS_PBLK: begin
        bus_need = `NVS_BUS_ERS_PBLK; // [R10]
        op_need = `NVS_OP_MASS;
      end
      `NVS_CMD_ERS_PSEC: begin
        bus_need = CMD.worst_case ? `NVS_BUS_ERS_PSEC_MAX : `NVS_BUS_ERS_PSEC_TYP; // [R11]
        op_need = `NVS_OP_ERS_PSEC;
      end
      `NVS_CMD_UNSECURE: begin
        bus_need = `NVS_BUS_ERS_ALL; // [R12]
        op_need = `NVS_OP_MASS;
      end
      `NVS_CMD_KEY: bus_need = `NVS_BUS_KEY; // [R13]
      `NVS_CMD_MRG_USER: bus_need = `NVS_BUS_MARGIN; // [R14]
      `NVS_CMD_MRG_FIELD: bus_need = `NVS_BUS_MARGIN; // [R15]
      `NVS_CMD_CHK_DSEC: begin
        bus_need = `NVS_BUS_SEC_SETUP + {4'h0, CMD.phrase_count}; // [R16]
        early_exit = 1'b1;
      end
      `NVS_CMD_PGM_D: begin
        // Per-word figure is the only part that differs at worst case. [R17]
        bus_need = 20'(`NVS_BUS_PGMD_BASE
          + nw * (CMD.worst_case ? `NVS_BUS_PGMD_WORD_MAX : `NVS_BUS_PGMD_WORD_TYP)
          + bc * `NVS_BUS_PGMD_BC);
        op_need = 20'(`NVS_OP_PGMD_BASE + nw * `NVS_OP_PGMD_WORD + bc * `NVS_OP_PGMD_BC);
      end
      `NVS_CMD_ERS_DSEC: begin
        // Worn-part figures stand in for the maximum here. [R18]
        bus_need = CMD.worst_case ? `NVS_BUS_ERS_DSEC_WORN : `NVS_BUS_ERS_DSEC_NEW;
        op_need = CMD.worst_case ? `NVS_OP_ERS_DSEC_WORN : `NVS_OP_ERS_DSEC_NEW;
      end
      default: known = 1'b0;
    endcase
  end

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  nvs_state_t state_reg; // Current state.
  nvs_state_t state_next; // Next state.
  logic [19:0] bus_left_reg; // Bus cycles still to run.
  logic [19:0] bus_left_next; // Next bus count.
  logic [19:0] op_left_reg; // Operating cycles still to run.
  logic [19:0] op_left_next; // Next operating count.
  logic early_reg; // Running command may end at a non-blank word.
  logic early_next; // Next early flag.
  logic busy_reg; // Busy output.
  logic busy_next; // Next busy.
  logic done_reg; // Complete pulse.
  logic done_next; // Next complete.
  logic err_reg; // Unknown code pulse.
  logic err_next; // Next error.
  logic fail_reg; // Non-blank found, held until next start.
  logic fail_next; // Next fail.

  // Counts both budgets down; completion needs both at zero.
  // A start while busy is ignored, since the array is in use.
  always_comb begin
    state_next = state_reg;
    bus_left_next = bus_left_reg;
    op_left_next = op_left_reg;
    early_next = early_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    err_next = 1'b0;
    fail_next = fail_reg;
    unique case (state_reg)
      NVS_IDLE: begin
        if (CMD_START) begin
          fail_next = 1'b0;
          if (known) begin
            state_next = NVS_RUN;
            bus_left_next = bus_need;
            op_left_next = op_need;
            early_next = early_exit;
            busy_next = 1'b1; // [R19]
          end else begin
            err_next = 1'b1;
          end
        end
      end
      NVS_RUN: begin
        if (bus_left_reg != 20'h0_0000) begin
          bus_left_next = bus_left_reg - 20'h0_0001;
        end
        if (op_left_reg != 20'h0_0000 && op_tick) begin
          op_left_next = op_left_reg - 20'h0_0001;
        end
        // Blank checks stop on the first non-blank word. [R3]
        if (early_reg && NONBLANK) begin
          fail_next = 1'b1;
          bus_left_next = 20'h0_0000;
        end
        if (bus_left_next == 20'h0_0000 && op_left_next == 20'h0_0000) begin
          state_next = NVS_IDLE;
          busy_next = 1'b0;
          done_next = 1'b1; // [R19]
        end
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_reg <= NVS_IDLE;
      bus_left_reg <= 20'h0_0000;
      op_left_reg <= 20'h0_0000;
      early_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bus_left_reg <= bus_left_next;
      op_left_reg <= op_left_next;
      early_reg <= early_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      err_reg <= err_next;
      fail_reg <= fail_next;
    end
  end

  assign BUSY = busy_reg;
  assign CMD_COMPLETE = done_reg;
  assign CMD_ERROR = err_reg;
  assign BLANK_FAIL = fail_reg;
endmodule : nvs_sequencer

//--- verilog/nvs_regs.svh
// Summary of operation
// R1: Operating clock divided from bus clock by software divider.
// R2: Divider range is never checked nor enforced.
// R3: Blank check all: 19200 cycles, early exit.
// R4: Blank check block: 17200 program, 2800 data.
// R5: Program section check: 450 plus phrase count.
// R6: One-time field read within 400 bus cycles.
// R7: Program phrase: 164 op plus 2000/2500 bus.
// R8: Program one-time field: 164 op plus 2150.
// R9: Erase all: 100100 op plus 38000 bus.
// R10: Erase program block: 100100 op plus 35000.
// R11: Sector erase: 20020 op plus 700/1400 bus.
// R12: Unsecure: 100100 op plus 38000 bus.
// R13: Back-door key check within 400 bus cycles.
// R14: User margin set within 350 bus cycles.
// R15: Field margin set within 350 bus cycles.
// R16: Data section check: 450 plus word count.
// R17: Data program: formula in words and boundary.
// R18: Data sector erase: 5025/700 new, 20100/3400 worn.
// R19: Busy while running; complete after both counts.
//
// This header holds command codes and cycle figures of the sequencer.
// It assumes inclusion by the sequencer and checker modules only.
`ifndef NVS_REGS_SVH
`define NVS_REGS_SVH

// ****************************************************************
// Command codes
// ****************************************************************
`define NVS_CMD_CHK_ALL 8'h01
`define NVS_CMD_CHK_BLK 8'h02
`define NVS_CMD_CHK_PSEC 8'h03
`define NVS_CMD_RD_ONCE 8'h04
`define NVS_CMD_PGM_P 8'h06
`define NVS_CMD_PGM_ONCE 8'h07
`define NVS_CMD_ERS_ALL 8'h08
`define NVS_CMD_ERS_PBLK 8'h09
`define NVS_CMD_ERS_PSEC 8'h0A
`define NVS_CMD_UNSECURE 8'h0B
`define NVS_CMD_KEY 8'h0C
`define NVS_CMD_MRG_USER 8'h0D
`define NVS_CMD_MRG_FIELD 8'h0E
`define NVS_CMD_CHK_DSEC 8'h10
`define NVS_CMD_PGM_D 8'h11
`define NVS_CMD_ERS_DSEC 8'h12

// ****************************************************************
// Bus-cycle and operating-cycle figures
// ****************************************************************
`define NVS_BUS_CHK_ALL 20'h0_4B00
`define NVS_BUS_CHK_PBLK 20'h0_4330
`define NVS_BUS_CHK_DBLK 20'h0_0AF0
`define NVS_BUS_SEC_SETUP 20'h0_01C2
`define NVS_BUS_RD_ONCE 20'h0_0190
`define NVS_BUS_PGM_P_TYP 20'h0_07D0
`define NVS_BUS_PGM_P_MAX 20'h0_09C4
`define NVS_BUS_PGM_ONCE 20'h0_0866
`define NVS_BUS_ERS_ALL 20'h0_9470
`define NVS_BUS_ERS_PBLK 20'h0_88B8
`define NVS_BUS_ERS_PSEC_TYP 20'h0_02BC
`define NVS_BUS_ERS_PSEC_MAX 20'h0_0578
`define NVS_BUS_KEY 20'h0_0190
`define NVS_BUS_MARGIN 20'h0_015E
`define NVS_BUS_PGMD_BASE 20'h0_01F4
`define NVS_BUS_PGMD_WORD_TYP 20'h0_020D
`define NVS_BUS_PGMD_WORD_MAX 20'h0_02EE
`define NVS_BUS_PGMD_BC 20'h0_0064
`define NVS_BUS_ERS_DSEC_NEW 20'h0_02BC
`define NVS_BUS_ERS_DSEC_WORN 20'h0_0D48
`define NVS_OP_PGM 20'h0_00A4
`define NVS_OP_MASS 20'h1_8704
`define NVS_OP_ERS_PSEC 20'h0_4E34
`define NVS_OP_PGMD_BASE 20'h0_000E
`define NVS_OP_PGMD_WORD 20'h0_0036
`define NVS_OP_PGMD_BC 20'h0_000E
`define NVS_OP_ERS_DSEC_NEW 20'h0_13A1
`define NVS_OP_ERS_DSEC_WORN 20'h0_4E84

`endif

//--- verilog/nvs_pkg.sv
// This package holds the types shared by the sequencer modules.
// It assumes the constant header is on the include path.
package nvs_pkg;
  // A command request as software presents it.
  typedef struct packed {
    logic [7:0] flash_command_code; // Command code.
    logic [15:0] phrase_count; // Phrases or words to verify.
    logic [2:0] word_count; // Data words to program, 1 to 4.
    logic row_boundary_crossed; // Data program crosses a row.
    logic data_block; // Blank check targets the data block.
    logic worst_case; // Use the maximum timing figures.
  } nvs_cmd_t;

  // Sequencer states.
  typedef enum logic [1:0] {NVS_IDLE, NVS_RUN} nvs_state_t;
endpackage : nvs_pkg

//--- verilog/nvs_clk_div.sv
// This file holds the operating clock tick generator.
// It assumes a divider value that stays constant while a command runs.
`timescale 1ns/100ps
module nvs_clk_div
  import nvs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] nvm_clock_divider,
  output logic op_tick
);
  // ****************************************************************
  // Divider counter
  // ****************************************************************
  logic [7:0] cnt_reg; // Bus cycles since last tick.
  logic [7:0] cnt_next; // Next count.
  logic tick_reg; // Registered tick.
  logic tick_next; // Next tick.

  // One tick every divider+1 bus cycles; the range is never checked. [R1] [R2]
  always_comb begin
    if (cnt_reg >= nvm_clock_divider) begin
      cnt_next = 8'h00;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 8'h01;
      tick_next = 1'b0;
    end
  end

  // Registers only.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign op_tick = tick_reg;
endmodule : nvs_clk_div

//--- testbench/nvs_seq_properties.sv
// Concurrent checks on the ports of the command timing sequencer.
// Assumes it is bound to nvs_sequencer and that NONBLANK and CMD share its clock.
`include "nvs_regs.svh"
`timescale 1ns/100ps
module nvs_seq_properties
  import nvs_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [7:0] NVM_CLOCK_DIVIDER,
  input wire logic CMD_START,
  input wire nvs_cmd_t CMD,
  input wire logic NONBLANK,
  input wire logic BUSY,
  input wire logic CMD_COMPLETE,
  input wire logic CMD_ERROR,
  input wire logic BLANK_FAIL
);
  // ****************
  // Capture of the running command
  // ****************
  nvs_cmd_t cur_reg, cur_next; // Command taken at the last start.
  logic [19:0] cnt_reg, cnt_next; // Cycles since that start, saturating.
  logic [7:0] rc; // Code of the running command.
  logic take; // A start that the block accepts.
  logic kn; // Code on the command input is one the block runs.
  assign rc = cur_reg.flash_command_code;
  assign kn = CMD.flash_command_code inside {[8'h01:8'h04], [8'h06:8'h0E], [8'h10:8'h12]};
  assign take = CMD_START && !BUSY;

  // Next values; the counter saturates so an idle block never wraps to a false match.
  always_comb begin
    cur_next = cur_reg;
    cnt_next = (&cnt_reg) ? cnt_reg : cnt_reg + 20'h0_0001;
    if (take) begin
      cur_next = CMD;
      cnt_next = '0;
    end
  end

  // Registers only.
  always_ff @(posedge SYS_CLK) begin
    cur_reg <= RST ? '0 : cur_next;
    cnt_reg <= RST ? '1 : cnt_next;
  end

  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence s_take;
    CMD_START && !BUSY;
  endsequence
  sequence s_known;
    kn;
  endsequence
  property p_start_busy; s_take ##0 s_known |=> BUSY; endproperty
  property p_bad_code; s_take ##0 !CMD_ERROR && !kn |=> CMD_ERROR && !BUSY; endproperty
  property p_refused; BUSY && CMD_START |=> !CMD_ERROR; endproperty
  property p_cmp_end; CMD_COMPLETE |-> !BUSY && $past(BUSY); endproperty
  property p_cmp_pulse; CMD_COMPLETE |=> !CMD_COMPLETE; endproperty
  property p_margin; CMD_COMPLETE && rc inside {8'h0D, 8'h0E} |-> cnt_reg == `NVS_BUS_MARGIN; endproperty
  property p_key; CMD_COMPLETE && rc inside {8'h04, 8'h0C} |-> cnt_reg == `NVS_BUS_KEY; endproperty
  property p_section;
    CMD_COMPLETE && !BLANK_FAIL && rc inside {8'h03, 8'h10} |-> cnt_reg == `NVS_BUS_SEC_SETUP + cur_reg.phrase_count;
  endproperty
  property p_nonblank; BUSY && NONBLANK && rc inside {8'h01, 8'h02, 8'h03, 8'h10} |=> CMD_COMPLETE && BLANK_FAIL; endproperty
  property p_pgm;
    CMD_COMPLETE && rc == 8'h06 && !cur_reg.worst_case && NVM_CLOCK_DIVIDER == 8'h00 |-> cnt_reg == `NVS_BUS_PGM_P_TYP;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy did not follow start");
  a_bad_code: assert property (p_bad_code) else $error("unknown code not flagged");
  a_refused: assert property (p_refused) else $error("start while busy was acted on");
  a_cmp_end: assert property (p_cmp_end) else $error("complete without busy ending");
  a_cmp_pulse: assert property (p_cmp_pulse) else $error("complete longer than one cycle");
  a_margin: assert property (p_margin) else $error("margin command length wrong");
  a_key: assert property (p_key) else $error("read once or key length wrong");
  a_section: assert property (p_section) else $error("section check length wrong");
  a_nonblank: assert property (p_nonblank) else $error("no early end on nonblank");
  a_pgm: assert property (p_pgm) else $error("phrase program length wrong");
endmodule : nvs_seq_properties

bind nvs_sequencer nvs_seq_properties u_chk (.SYS_CLK, .RST, .NVM_CLOCK_DIVIDER, .CMD_START, .CMD, .NONBLANK,
  .BUSY, .CMD_COMPLETE, .CMD_ERROR, .BLANK_FAIL);

//--- testbench/nvs_sequencer_bench.sv
// Self-checking bench of the command timing sequencer.
// Assumes the checker file is compiled beside it; a table row is one command.
`timescale 1ns/100ps
module nvs_sequencer_bench
  import nvs_pkg::*;
;
  typedef struct packed {
    logic [7:0] d;
    nvs_cmd_t c;
    logic [19:0] lo;
    logic [7:0] tol, nb, pk;
  } nvs_row_t;
  nvs_row_t rows[$]; // Divider, command, first legal length, slack, nonblank and extra-start cycles.
  logic [7:0] longs [3] = '{8'h08, 8'h09, 8'h0B}; // Too long to finish; cut by reset.
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] div = 8'h00;
  logic start = 1'b0;
  nvs_cmd_t cmd = '0;
  logic nonblank = 1'b0;
  logic busy, cmp, err, bfail;
  int error_cnt = 0;
  int n_checks = 0;

  always #2.5 sys_clk = ~sys_clk;

  nvs_sequencer DUT (.SYS_CLK(sys_clk), .RST(rst), .NVM_CLOCK_DIVIDER(div), .CMD_START(start), .CMD(cmd),
    .NONBLANK(nonblank), .BUSY(busy), .CMD_COMPLETE(cmp), .CMD_ERROR(err), .BLANK_FAIL(bfail));

  task chk(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task tally_and_finish;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task add(input logic [7:0] d, input nvs_cmd_t c, input logic [19:0] lo, input logic [7:0] tol, nb, pk);
    rows.push_back('{d, c, lo, tol, nb, pk});
  endtask : add

  // Starts one command and counts edges until completion; op-clock rows get slack for the divider phase.
  task run(input nvs_row_t r);
    int n;
    n = 0;
    @(posedge sys_clk);
    div <= r.d;
    start <= 1'b1;
    cmd <= r.c;
    @(posedge sys_clk);
    start <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
      nonblank <= (n == r.nb);
      start <= (n == r.pk);
      #1;
      if (n == 1) chk(bfail, 1'b0);
      if (!cmp) chk(busy, 1'b1);
    end while (!cmp && n < 30000);
    if (!cmp) begin
      error_cnt++;
      tally_and_finish();
    end
    chk(busy, 1'b0);
    chk(err, 1'b0);
    chk(bfail, r.nb != 0);
    chk(n >= r.lo && n <= r.lo + r.tol, 1'b1);
  endtask : run

  initial begin
    add(8'h00, {8'h0D, 16'h0000, 6'h00}, 20'h0_015E, 8'h00, 8'h00, 8'h64);
    add(8'h00, {8'h0E, 16'h0000, 6'h00}, 20'h0_015E, 8'h00, 8'h00, 8'h00);
    add(8'h00, {8'h04, 16'h0000, 6'h00}, 20'h0_0190, 8'h00, 8'h00, 8'h00);
    add(8'h00, {8'h0C, 16'h0000, 6'h00}, 20'h0_0190, 8'h00, 8'h00, 8'h00);
    add(8'h00, {8'h03, 16'h000A, 6'h00}, 20'h0_01CC, 8'h00, 8'h00, 8'h00);
    add(8'h00, {8'h10, 16'h0005, 6'h00}, 20'h0_01C7, 8'h00, 8'h00, 8'h00);
    add(8'h00, {8'h02, 16'h0000, 6'h02}, 20'h0_0AF0, 8'h00, 8'h00, 8'h00);
    add(8'h00, {8'h02, 16'h0000, 6'h00}, 20'h0_4330, 8'h00, 8'h00, 8'h00);
    add(8'h00, {8'h06, 16'h0000, 6'h00}, 20'h0_07D0, 8'h00, 8'h00, 8'h00);
    add(8'h00, {8'h06, 16'h0000, 6'h01}, 20'h0_09C4, 8'h00, 8'h00, 8'h00);
    add(8'h00, {8'h07, 16'h0000, 6'h00}, 20'h0_0866, 8'h00, 8'h00, 8'h00);
    add(8'h00, {8'h11, 16'h0000, 6'h24}, 20'h0_0A8C, 8'h00, 8'h00, 8'h00);
    add(8'h00, {8'h11, 16'h0000, 6'h09}, 20'h0_04E2, 8'h00, 8'h00, 8'h00);
    add(8'h00, {8'h0A, 16'h0000, 6'h00}, 20'h0_4E34, 8'h03, 8'h00, 8'h00);
    add(8'h00, {8'h12, 16'h0000, 6'h00}, 20'h0_13A1, 8'h03, 8'h00, 8'h00);
    add(8'h00, {8'h12, 16'h0000, 6'h01}, 20'h0_4E84, 8'h03, 8'h00, 8'h00);
    add(8'h00, {8'h01, 16'h0000, 6'h00}, 20'h0_0033, 8'h00, 8'h32, 8'h00);
    add(8'h00, {8'h10, 16'h0005, 6'h00}, 20'h0_0015, 8'h00, 8'h14, 8'h00);
    add(8'hFF, {8'h0D, 16'h0000, 6'h00}, 20'h0_015E, 8'h00, 8'h00, 8'h00);
    add(8'h0F, {8'h06, 16'h0000, 6'h00}, 20'h0_0A28, 8'h32, 8'h00, 8'h00);
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({busy, cmp, err, bfail}, 4'h0);
    foreach (rows[i]) run(rows[i]);
    // An unknown code is flagged for one cycle and never starts a run.
    @(posedge sys_clk);
    start <= 1'b1;
    cmd <= {8'h05, 16'h0000, 6'h00};
    @(posedge sys_clk);
    start <= 1'b0;
    #1;
    chk({err, busy}, 2'h2);
    @(posedge sys_clk);
    #1;
    chk(err, 1'b0);
    // Mass erases outlast the bench; check they stay busy, then cut them by reset.
    foreach (longs[i]) begin
      @(posedge sys_clk);
      start <= 1'b1;
      cmd <= {longs[i], 16'h0000, 6'h00};
      @(posedge sys_clk);
      start <= 1'b0;
      repeat (1000) @(posedge sys_clk);
      #1;
      chk({busy, cmp}, 2'h2);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      chk({busy, cmp}, 2'h0);
    end
    tally_and_finish();
  end
endmodule : nvs_sequencer_bench
